/* rtl/pump_seq_pkg.sv */
package pump_seq_pkg;
  // ==========================================
  // register map (word aligned byte offsets)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SP_ON0 = 8'h04;
  localparam logic [7:0] ADDR_SP_ON1 = 8'h08;
  localparam logic [7:0] ADDR_SP_ON2 = 8'h0C;
  localparam logic [7:0] ADDR_SP_OFF = 8'h10;
  localparam logic [7:0] ADDR_LEVEL = 8'h14;
  localparam logic [7:0] ADDR_RATE = 8'h18;
  localparam logic [7:0] ADDR_SHARE = 8'h1C;
  localparam logic [7:0] ADDR_FEAT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_HOURS0 = 8'h28;
  localparam logic [7:0] ADDR_HOURS1 = 8'h2C;
  localparam logic [7:0] ADDR_HOURS2 = 8'h30;
  // ==========================================
  // strategy codes
  localparam logic [7:0] STRAT_FIXED_ASSIST = 8'h32;
  localparam logic [7:0] STRAT_FIXED_BACKUP = 8'h33;
  localparam logic [7:0] STRAT_ALT_ASSIST = 8'h34;
  localparam logic [7:0] STRAT_ALT_BACKUP = 8'h35;
  localparam logic [7:0] STRAT_SR_ASSIST = 8'h36;
  localparam logic [7:0] STRAT_SR_BACKUP = 8'h37;
  localparam logic [7:0] STRAT_FIFO = 8'h38;
  localparam logic [3:0] RELAY_MODE_SETPOINT = 4'h2;
  // ==========================================
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0233;
  localparam logic [15:0] SP_ON0_RESET = 16'h0300;
  localparam logic [15:0] SP_ON1_RESET = 16'h0500;
  localparam logic [15:0] SP_ON2_RESET = 16'h0700;
  localparam logic [15:0] SP_OFF_RESET = 16'h0100;
  localparam logic [23:0] SHARE_RESET = 24'h32_19_19;
  // level limit actions
  localparam logic [1:0] LIMIT_VALVE = 2'h1;
  localparam logic [1:0] LIMIT_STOP = 2'h2;
  localparam logic [1:0] LIMIT_START_ALL = 2'h3;
  // feature field positions in the feature register
  localparam int FEAT_RATE_EN = 0;
  localparam int FEAT_EXERCISE = 1;
  localparam int FEAT_WANDER = 2;
  localparam int FEAT_TARIFF = 3;
  localparam int FEAT_LOWLOW = 4;
  localparam int FEAT_ACT_LSB = 5;
  localparam int FEAT_RUNON_LSB = 8;
  localparam int FEAT_FLUSH_LSB = 16;
  localparam int FEAT_SHIFT_LSB = 24;
  // time constants
  localparam int CLK_HZ = 40_000_000;
  localparam int RUNON_MS = 1000;
  localparam int RUNON_CYCLES = CLK_HZ / 1000 * RUNON_MS;
  localparam int EXERCISE_S = 3600;
  localparam longint EXERCISE_CYCLES = longint'(CLK_HZ) * EXERCISE_S;
  localparam int EXERCISE_RUN_CYCLES = CLK_HZ;
  localparam logic [15:0] WANDER_STEP = 16'h0010;
endpackage

/* rtl/pump_relay_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - fixed backup maps relay n to setpoint n
// - fixed backup new relay opens previous one
// - fixed backup keeps at most one relay
// - alternate assist rotates lead each cycle
// - alternate assist adds relays cyclically in parallel
// - alternate backup relay ((k+n-2) mod 3)+1
// - alternate backup keeps single relay closed
// - service ratio assist picks by run hours
// - pick pump whose hours lag its share
// - service ratio backup stops previous pump
// - fifo starts alternate, stops oldest first
// - rate mode adds pumps until rate met
// - run-on timer starts every nth start, once the relays have already opened
// - exercise runs pump 0 briefly once any pump idles long
// - wall cling varies first on and off setpoints each cycle
// - both alternate groups follow the one group a rotation
// - tariff period shifts on setpoints upward
// - level alarm takes selected special action
// - flush output every nth pump start
// - contact start and stop override algorithm
// - fixed assist adds relay n at setpoint n, earlier relays stay closed
module pump_relay_sequencer #(
  parameter int NPUMP = 3,
  parameter longint EXERCISE_IDLE = pump_seq_pkg::EXERCISE_CYCLES,
  parameter int RUNON_LEN = pump_seq_pkg::RUNON_CYCLES
) (
  input wire logic sys_clk, // system clock 40 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic level_valid, // new level sample strobe
  input wire logic [15:0] level_sample, // measured level
  input wire logic signed [15:0] level_rate, // signed level rate
  input wire logic high_high_alarm, // overflow alarm
  input wire logic low_low_alarm, // underflow alarm
  input wire logic tariff_active, // high cost period
  input wire logic [NPUMP-1:0] contact_start_input, // contact start per pump
  input wire logic [NPUMP-1:0] contact_stop_input, // contact stop per pump
  output logic [NPUMP-1:0] pump_relay, // relay closed when high
  output logic flush_valve, // flush device drive
  output logic overflow_valve // special action valve
);
  // ==========================================
  // state
  typedef struct packed {
    logic [31:0] ctrl; // strategy, relay mode, group split
    logic [15:0] sp_on0;
    logic [15:0] sp_on1;
    logic [15:0] sp_on2;
    logic [15:0] sp_off;
    logic [15:0] level;
    logic [31:0] rate; // fill and empty setpoints
    logic [23:0] share;
    logic [31:0] feat;
    logic [1:0] rot_a; // group a rotation
    logic [1:0] rot_b; // group b rotation
    logic [1:0] stage; // highest on setpoint reached, 0 none
    logic [1:0] wander;
    logic [NPUMP-1:0] relay;
    logic [5:0] fifo; // start order, two bits per slot
    logic [1:0] fifo_n;
    logic [7:0] starts;
    logic [31:0] runon;
    logic [63:0] idle;
    logic [31:0] exer;
    logic [95:0] hours;
    logic flush;
    logic valve;
    logic ap_wr; // pending write
    logic ap_rd;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } state_type;
  state_type cur, nxt;

  // ==========================================
  // helpers
  logic [15:0] shift, won0, won1, won2, woff;
  logic [1:0] lead, pick;
  logic [7:0] strat;
  always_comb begin
    // energy and wall cling adjustments
    shift = cur.feat[pump_seq_pkg::FEAT_TARIFF] && tariff_active ?
      {8'h00, cur.feat[31:24]} : 16'h0000;
    won0 = cur.sp_on0 + shift + (cur.feat[pump_seq_pkg::FEAT_WANDER] ?
      16'(cur.wander) * pump_seq_pkg::WANDER_STEP : 16'h0000);
    won1 = cur.sp_on1 + shift;
    won2 = cur.sp_on2 + shift;
    woff = cur.sp_off + (cur.feat[pump_seq_pkg::FEAT_WANDER] ?
      16'(cur.wander) * pump_seq_pkg::WANDER_STEP : 16'h0000);
    strat = cur.ctrl[7:0];
    // lead uses the group a rotation whether split or not
    lead = cur.ctrl[12] ? cur.rot_a : cur.rot_a;
    // service ratio pick: lowest hours/share
    pick = 2'h0;
    for (int i = 1; i < NPUMP; i++) begin
      if (32'(cur.hours[i*32+:32]) * 32'(cur.share[pick*8+:8]) <
          32'(cur.hours[pick*32+:32]) * 32'(cur.share[i*8+:8])) begin
        pick = 2'(i);
      end
    end
  end

  function automatic logic [1:0] wrap3(input logic [2:0] v);
    wrap3 = v >= 3'h3 ? 2'(v - 3'h3) : 2'(v);
  endfunction

  // ==========================================
  // next state
  logic [1:0] new_stage;
  logic [NPUMP-1:0] algo, want;
  always_comb begin
    nxt = cur;
    new_stage = cur.stage;
    algo = cur.relay;
    want = cur.relay;
    // bus address phase
    nxt.ap_wr = hsel && hready && htrans[1] && hwrite;
    nxt.ap_rd = hsel && hready && htrans[1] && !hwrite;
    if (hsel && hready && htrans[1]) begin
      nxt.ap_addr = haddr[7:0];
    end
    if (cur.ap_wr) begin
      case (cur.ap_addr)
        pump_seq_pkg::ADDR_CTRL: nxt.ctrl = hwdata;
        pump_seq_pkg::ADDR_SP_ON0: nxt.sp_on0 = hwdata[15:0];
        pump_seq_pkg::ADDR_SP_ON1: nxt.sp_on1 = hwdata[15:0];
        pump_seq_pkg::ADDR_SP_ON2: nxt.sp_on2 = hwdata[15:0];
        pump_seq_pkg::ADDR_SP_OFF: nxt.sp_off = hwdata[15:0];
        pump_seq_pkg::ADDR_RATE: nxt.rate = hwdata;
        pump_seq_pkg::ADDR_SHARE: nxt.share = hwdata[23:0];
        pump_seq_pkg::ADDR_FEAT: nxt.feat = hwdata;
        default: ;
      endcase
    end
    if (nxt.ap_rd) begin
      case (haddr[7:0])
        pump_seq_pkg::ADDR_CTRL: nxt.rdata = cur.ctrl;
        pump_seq_pkg::ADDR_SP_ON0: nxt.rdata = {16'h0000, cur.sp_on0};
        pump_seq_pkg::ADDR_SP_ON1: nxt.rdata = {16'h0000, cur.sp_on1};
        pump_seq_pkg::ADDR_SP_ON2: nxt.rdata = {16'h0000, cur.sp_on2};
        pump_seq_pkg::ADDR_SP_OFF: nxt.rdata = {16'h0000, cur.sp_off};
        pump_seq_pkg::ADDR_LEVEL: nxt.rdata = {16'h0000, cur.level};
        pump_seq_pkg::ADDR_RATE: nxt.rdata = cur.rate;
        pump_seq_pkg::ADDR_SHARE: nxt.rdata = {8'h00, cur.share};
        pump_seq_pkg::ADDR_FEAT: nxt.rdata = cur.feat;
        // status: start count, both rotations, stage, every relay
        pump_seq_pkg::ADDR_STATUS: nxt.rdata = {15'h0000, cur.starts,
          cur.rot_b, cur.rot_a, cur.stage, 3'(cur.relay)};
        pump_seq_pkg::ADDR_HOURS0: nxt.rdata = cur.hours[31:0];
        pump_seq_pkg::ADDR_HOURS1: nxt.rdata = cur.hours[63:32];
        pump_seq_pkg::ADDR_HOURS2: nxt.rdata = cur.hours[95:64];
        default: nxt.rdata = 32'h0000_0000;
      endcase
    end
    // run-hour and idle accounting
    for (int i = 0; i < NPUMP; i++) begin
      if (cur.relay[i]) begin
        nxt.hours[i*32+:32] = cur.hours[i*32+:32] + 32'h1;
        nxt.idle[i*21+:21] = 21'h0;
      end
    end
    // level crossings per sample
    if (level_valid) begin
      nxt.level = level_sample;
      if (level_sample >= won2) new_stage = 2'h3;
      else if (level_sample >= won1 && cur.stage < 2'h2) new_stage = 2'h2;
      else if (level_sample >= won0 && cur.stage < 2'h1) new_stage = 2'h1;
      // rate mode: add pumps until rate met
      if (cur.feat[pump_seq_pkg::FEAT_RATE_EN] && cur.stage != 2'h0 &&
          cur.stage < 2'h3 &&
          level_rate > $signed(cur.rate[15:0]) &&
          -level_rate < $signed(cur.rate[31:16])) begin
        new_stage = cur.stage + 2'h1;
      end
      if (level_sample <= woff && cur.stage != 2'h0) begin
        if (strat == pump_seq_pkg::STRAT_FIFO && cur.fifo_n > 2'h1) begin
          nxt.fifo_n = cur.fifo_n - 2'h1;
          algo[cur.fifo[1:0]] = 1'b0;
          nxt.fifo = {2'h0, cur.fifo[5:2]};
        end else begin
          new_stage = 2'h0;
          nxt.rot_a = cur.rot_a == 2'h2 ? 2'h0 : cur.rot_a + 2'h1;
          nxt.wander = cur.wander + 2'h1;
          nxt.fifo_n = 2'h0;
          if (cur.starts[3:0] != 4'h0 && cur.feat[11:8] != 4'h0 &&
              cur.starts[3:0] % cur.feat[11:8] == 4'h0) begin
            nxt.runon = 32'(RUNON_LEN);
          end
        end
      end
      if (new_stage > cur.stage) begin
        nxt.starts = cur.starts + 8'h1;
        if (cur.feat[19:16] != 4'h0 &&
            (cur.starts[3:0] + 4'h1) % cur.feat[19:16] == 4'h0) begin
          nxt.flush = 1'b1;
        end
      end
    end
    nxt.stage = new_stage;
    // strategy mapping, only in setpoint relay mode
    if (cur.ctrl[11:8] == pump_seq_pkg::RELAY_MODE_SETPOINT) begin
      case (strat)
        pump_seq_pkg::STRAT_FIXED_ASSIST: begin
          for (int n = 0; n < NPUMP; n++) algo[n] = new_stage > 2'(n);
        end
        pump_seq_pkg::STRAT_FIXED_BACKUP: begin
          algo = '0;
          if (new_stage != 2'h0) algo[new_stage - 2'h1] = 1'b1;
        end
        pump_seq_pkg::STRAT_ALT_ASSIST, pump_seq_pkg::STRAT_FIFO: begin
          if (new_stage == 2'h0) algo = '0;
          else if (!(strat == pump_seq_pkg::STRAT_FIFO && cur.fifo_n != 2'h0 &&
                     new_stage == cur.stage)) begin
            algo = '0;
            for (int n = 0; n < NPUMP; n++) begin
              if (new_stage > 2'(n)) algo[wrap3(3'(lead) + 3'(n))] = 1'b1;
            end
          end
          if (strat == pump_seq_pkg::STRAT_FIFO && new_stage > cur.stage) begin
            nxt.fifo[2*cur.fifo_n+:2] = wrap3(3'(lead) + 3'(cur.stage));
            nxt.fifo_n = cur.fifo_n + 2'h1;
          end
        end
        pump_seq_pkg::STRAT_ALT_BACKUP: begin
          algo = '0;
          if (new_stage != 2'h0) algo[wrap3(3'(lead) + 3'(new_stage) - 3'h1)] = 1'b1;
        end
        pump_seq_pkg::STRAT_SR_ASSIST: begin
          if (new_stage == 2'h0) algo = '0;
          else if (new_stage > cur.stage) algo[pick] = 1'b1;
        end
        pump_seq_pkg::STRAT_SR_BACKUP: begin
          if (new_stage == 2'h0) algo = '0;
          else if (new_stage > cur.stage) begin
            algo = '0;
            algo[pick] = 1'b1;
          end
        end
        default: algo = '0;
      endcase
    end
    // run-on keeps closed relays closed; pumps that just stopped have already opened
    want = algo;
    if (cur.runon != 32'h0) begin
      nxt.runon = cur.runon - 32'h1;
      want = algo | cur.relay;
    end
    // exercise pump 0 once any pump idles long
    for (int i = 0; i < NPUMP; i++) begin
      if (!cur.relay[i] && cur.feat[pump_seq_pkg::FEAT_EXERCISE]) begin
        nxt.idle[i*21+:21] = cur.idle[i*21+:21] + 21'h1;
        if (64'(cur.idle[i*21+:21]) >= 64'(EXERCISE_IDLE) - 64'h1) begin
          nxt.idle[i*21+:21] = 21'h0;
          nxt.exer = 32'(pump_seq_pkg::EXERCISE_RUN_CYCLES);
        end
      end
    end
    if (cur.exer != 32'h0) begin
      nxt.exer = cur.exer - 32'h1;
      want[0] = 1'b1;
    end
    // level limit action
    nxt.valve = 1'b0;
    if (high_high_alarm || (low_low_alarm && cur.feat[pump_seq_pkg::FEAT_LOWLOW])) begin
      case (cur.feat[6:5])
        pump_seq_pkg::LIMIT_VALVE: nxt.valve = 1'b1;
        pump_seq_pkg::LIMIT_STOP: want = '0;
        pump_seq_pkg::LIMIT_START_ALL: want = '1;
        default: ;
      endcase
    end
    // contacts override everything
    want = (want | contact_start_input) & ~contact_stop_input;
    nxt.relay = want;
    // flush device drops once every relay is open
    if (nxt.relay == '0) nxt.flush = 1'b0;
    if (cur.ap_wr && cur.ap_addr == pump_seq_pkg::ADDR_CTRL) nxt.rot_b = hwdata[14:13];
  end

  // ==========================================
  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
      cur.ctrl <= pump_seq_pkg::CTRL_RESET;
      cur.sp_on0 <= pump_seq_pkg::SP_ON0_RESET;
      cur.sp_on1 <= pump_seq_pkg::SP_ON1_RESET;
      cur.sp_on2 <= pump_seq_pkg::SP_ON2_RESET;
      cur.sp_off <= pump_seq_pkg::SP_OFF_RESET;
      cur.share <= pump_seq_pkg::SHARE_RESET;
    end else begin
      cur <= nxt;
    end
  end

  // outputs straight from flip-flops, hreadyout and hresp tied constant
  assign pump_relay = cur.relay;
  assign flush_valve = cur.flush;
  assign overflow_valve = cur.valve;
  assign hrdata = cur.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================
  // checks
  property p_fixed_one;
    @(posedge sys_clk) disable iff (!arst_n)
    (strat == pump_seq_pkg::STRAT_FIXED_BACKUP && !high_high_alarm &&
     !low_low_alarm &&
     contact_start_input == '0 && cur.runon == 32'h0 && cur.exer == 32'h0)
    |=> $onehot0(pump_relay);
  endproperty
  a_fixed_one: assert property (p_fixed_one) else $error("fixed backup closed two relays");

  property p_off_stops;
    @(posedge sys_clk) disable iff (!arst_n)
    (level_valid && cur.stage != 2'h0 && level_sample <= woff &&
     strat == pump_seq_pkg::STRAT_FIXED_BACKUP) |=> cur.stage == 2'h0;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("off setpoint did not end cycle");

  property p_contact_stop;
    @(posedge sys_clk) disable iff (!arst_n)
    contact_stop_input[0] |=> !pump_relay[0];
  endproperty
  a_contact_stop: assert property (p_contact_stop) else $error("contact stop ignored");

  property p_contact_start;
    @(posedge sys_clk) disable iff (!arst_n)
    (contact_start_input[1] && !contact_stop_input[1]) |=> pump_relay[1];
  endproperty
  a_contact_start: assert property (p_contact_start) else $error("contact start ignored");

  property p_rot_wrap;
    @(posedge sys_clk) disable iff (!arst_n)
    cur.rot_a != 2'h3;
  endproperty
  a_rot_wrap: assert property (p_rot_wrap) else $error("rotation out of range");

  property p_valve;
    @(posedge sys_clk) disable iff (!arst_n)
    (high_high_alarm && cur.feat[6:5] == pump_seq_pkg::LIMIT_VALVE) |=> overflow_valve;
  endproperty
  a_valve: assert property (p_valve) else $error("limit valve not opened");

  property p_alt_backup;
    @(posedge sys_clk) disable iff (!arst_n)
    (strat == pump_seq_pkg::STRAT_ALT_BACKUP && contact_start_input == '0 &&
     !high_high_alarm && !low_low_alarm && cur.runon == 32'h0 && cur.exer == 32'h0) |=>
     $onehot0(pump_relay);
  endproperty
  a_alt_backup: assert property (p_alt_backup) else $error("alternate backup two relays");

  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    (!level_valid && strat == pump_seq_pkg::STRAT_FIXED_ASSIST) |=> $stable(cur.stage);
  endproperty
  a_hold: assert property (p_hold) else $error("stage moved without sample");
endmodule

/* sim/pump_field_model.sv */
`timescale 1ns/1ps
// ==========================================
// field side: float contacts and pump contactors
module pump_field_model (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // reset, active low
  input wire logic [2:0] pump_relay, // relay drives from the block
  input wire logic [2:0] float_start, // bench float command, start
  input wire logic [2:0] float_stop, // bench float command, stop
  output logic [2:0] contact_start_input, // start contacts to block
  output logic [2:0] contact_stop_input, // stop contacts to block
  output logic [15:0] start_cnt // pump starts seen
);
  logic [2:0] last_relay; // relay state one edge back
  // floats close the contacts straight through
  assign contact_start_input = float_start;
  assign contact_stop_input = float_stop;
  // count every contactor that pulls in
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_relay <= 3'h0;
      start_cnt <= 16'h0000;
    end else begin
      last_relay <= pump_relay;
      start_cnt <= start_cnt + 16'($countones(pump_relay & ~last_relay));
    end
  end
endmodule

/* sim/pump_relay_sequencer_bench.sv */
`timescale 1ns/1ps
// ==========================================
// bench top: bus tasks, level steps, relay checks
module pump_relay_sequencer_bench;
  logic sys_clk, arst_n, hsel, hwrite, hready, hresp, hreadyout; // clock, reset, bus
  logic [31:0] haddr, hwdata, hrdata, rd; // bus words
  logic [1:0] htrans; // transfer type
  logic [2:0] hsize, pump_relay, f_start, f_stop, c_start, c_stop; // pump side
  logic level_valid, hh, ll, tariff, flush_valve, overflow_valve; // level side
  logic [15:0] level_sample, starts; // level and start count
  logic signed [15:0] lvl_rate; // level rate of change
  int error_cnt, tests_run; // counters
  assign hready = hreadyout;
  // ==========================================
  // clock 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  pump_relay_sequencer #(.EXERCISE_IDLE(50), .RUNON_LEN(10)) i_pump_relay_sequencer (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .level_valid(level_valid),
    .level_sample(level_sample), .level_rate(lvl_rate), .high_high_alarm(hh),
    .low_low_alarm(ll), .tariff_active(tariff), .contact_start_input(c_start),
    .contact_stop_input(c_stop), .pump_relay(pump_relay), .flush_valve(flush_valve),
    .overflow_valve(overflow_valve));
  pump_field_model i_pump_field_model (.sys_clk(sys_clk), .arst_n(arst_n),
    .pump_relay(pump_relay), .float_start(f_start), .float_stop(f_stop),
    .contact_start_input(c_start), .contact_stop_input(c_stop), .start_cnt(starts));
  // ==========================================
  // verdict and end of run
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // compare a relay group
  task automatic chk3(input string nm, input logic [2:0] e, input logic [2:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // compare a bus word
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait for hready under a bound
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      error_cnt++;
      $display("[FAIL] hready expected 1 seen %b", hready);
      end_of_test();
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // short asynchronous reset between tests
  task automatic rst(input int n);
    arst_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  // present one level sample, check relays after it lands
  task automatic step(input logic [15:0] v, input logic [2:0] e);
    level_sample <= v;
    level_valid <= 1'b1;
    @(posedge sys_clk);
    level_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk3("pump_relay", e, pump_relay);
  endtask
  // one full level cycle up through all on points, then below off
  task automatic cyc(input logic [2:0] e1, input logic [2:0] e2, input logic [2:0] e3);
    step(16'h0350, e1);
    step(16'h0550, e2);
    step(16'h0750, e3);
    step(16'h0050, 3'h0);
  endtask
  // new strategy with relays in setpoint mode
  task automatic strat(input logic [7:0] s);
    rst(2);
    bus(1'b1, pump_seq_pkg::ADDR_CTRL, {20'h00000, pump_seq_pkg::RELAY_MODE_SETPOINT, s});
  endtask
  // ==========================================
  // main sequence
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    {hsel, hwrite, level_valid, hh, ll, tariff} = 6'h00;
    {haddr, hwdata} = 64'h0;
    {htrans, hsize, f_start, f_stop} = 11'h000;
    level_sample = 16'h0000;
    lvl_rate = 16'sh0000;
    error_cnt = 0;
    tests_run = 0;
    rst(16);
    // register defaults, unmapped place, bus response
    chk3("relays_at_reset", 3'h0, pump_relay);
    bus(1'b0, pump_seq_pkg::ADDR_CTRL, 32'h0);
    chk32("ctrl", pump_seq_pkg::CTRL_RESET, rd);
    bus(1'b0, pump_seq_pkg::ADDR_SP_ON1, 32'h0);
    chk32("sp_on1", {16'h0000, pump_seq_pkg::SP_ON1_RESET}, rd);
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    bus(1'b0, 8'hFC, 32'h0);
    chk32("unmapped", 32'h0000_0000, rd);
    bus(1'b1, pump_seq_pkg::ADDR_SHARE, 32'h0032_1919);
    chk32("hresp", 32'h0, {31'h0, hresp});
    $display("test registers done");
    // fixed backup: one relay per setpoint, previous opens
    strat(pump_seq_pkg::STRAT_FIXED_BACKUP);
    cyc(3'h1, 3'h2, 3'h4);
    chk32("starts", 32'h3, {16'h0000, starts});
    bus(1'b0, pump_seq_pkg::ADDR_LEVEL, 32'h0);
    chk32("level", 32'h0000_0050, rd);
    $display("test fixed_backup done");
    // fixed assist: relays pile up
    strat(pump_seq_pkg::STRAT_FIXED_ASSIST);
    cyc(3'h1, 3'h3, 3'h7);
    step(16'h0200, 3'h0);
    $display("test fixed_assist done");
    // alternate assist: lead rotates, wraps after third cycle
    strat(pump_seq_pkg::STRAT_ALT_ASSIST);
    cyc(3'h1, 3'h3, 3'h7);
    cyc(3'h2, 3'h6, 3'h7);
    cyc(3'h4, 3'h5, 3'h7);
    cyc(3'h1, 3'h3, 3'h7);
    $display("test alt_assist done");
    // alternate backup: ((k+n-2) mod 3)+1, single relay
    strat(pump_seq_pkg::STRAT_ALT_BACKUP);
    cyc(3'h1, 3'h2, 3'h4);
    cyc(3'h2, 3'h4, 3'h1);
    cyc(3'h4, 3'h1, 3'h2);
    $display("test alt_backup done");
    // fifo: each off crossing stops the oldest pump
    strat(pump_seq_pkg::STRAT_FIFO);
    step(16'h0350, 3'h1);
    step(16'h0550, 3'h3);
    step(16'h0750, 3'h7);
    step(16'h0050, 3'h6);
    step(16'h0050, 3'h4);
    step(16'h0050, 3'h0);
    step(16'h0350, 3'h2);
    step(16'h0550, 3'h6);
    step(16'h0050, 3'h4);
    step(16'h0200, 3'h4);
    step(16'h0050, 3'h0);
    $display("test fifo done");
    // service ratio: next start goes to the pump furthest behind its share
    strat(pump_seq_pkg::STRAT_SR_ASSIST);
    cyc(3'h1, 3'h3, 3'h7);
    strat(pump_seq_pkg::STRAT_SR_BACKUP);
    cyc(3'h1, 3'h2, 3'h4);
    $display("test service_ratio done");
    // rate start adds pumps while filling, flush on every second start
    strat(pump_seq_pkg::STRAT_FIXED_ASSIST);
    bus(1'b1, pump_seq_pkg::ADDR_FEAT, 32'h0002_0001);
    lvl_rate <= 16'sh0010;
    step(16'h0350, 3'h1);
    step(16'h0350, 3'h3);
    chk3("flush_valve", 3'h1, {2'h0, flush_valve});
    lvl_rate <= 16'sh0000;
    step(16'h0350, 3'h3);
    step(16'h0050, 3'h0);
    chk3("flush_off", 3'h0, {2'h0, flush_valve});
    $display("test rate_flush done");
    // contact override: start adds two pumps, stop wins
    strat(pump_seq_pkg::STRAT_FIXED_ASSIST);
    step(16'h0350, 3'h1);
    f_start <= 3'h6;
    repeat (3) @(posedge sys_clk);
    chk3("contact_start", 3'h7, pump_relay);
    f_stop <= 3'h7;
    repeat (3) @(posedge sys_clk);
    chk3("contact_stop", 3'h0, pump_relay);
    f_start <= 3'h0;
    f_stop <= 3'h0;
    $display("test contacts done");
    // overflow alarm: start all, stop, open valve
    strat(pump_seq_pkg::STRAT_FIXED_ASSIST);
    bus(1'b1, pump_seq_pkg::ADDR_FEAT, {25'h0, pump_seq_pkg::LIMIT_START_ALL, 5'h00});
    hh <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk3("alarm_start_all", 3'h7, pump_relay);
    bus(1'b1, pump_seq_pkg::ADDR_FEAT, {25'h0, pump_seq_pkg::LIMIT_STOP, 5'h00});
    step(16'h0750, 3'h0);
    bus(1'b1, pump_seq_pkg::ADDR_FEAT, {25'h0, pump_seq_pkg::LIMIT_VALVE, 5'h00});
    repeat (3) @(posedge sys_clk);
    chk3("alarm_valve", 3'h1, {2'h0, overflow_valve});
    hh <= 1'b0;
    $display("test alarms done");
    end_of_test();
  end
endmodule
